// ==== core/cts_status.sv ====
// clear-to-send modem status, register select, data bus and dma request pins
//
// Behaviour
// R1 - msr bit 4 shows the present clear-to-send condition
// R2 - msr bit 0 flags a clear-to-send change since last msr read, read clears
// R3 - change interrupt only when modem-status interrupt enabled and auto-cts off
// R4 - with auto-cts on, clear-to-send gates the transmitter
// R5 - four address lines with chip select pick exactly one register
// R6 - host asserts chip select low; device ignores cycles without it
// R7 - data bus bit 0 is lsb, bit 7 is msb
// R8 - dma controller answers each request with its own low acknowledge
// R9 - dma requests are active high on the selected channel
// R10 - clear-to-send is synchronised before change detection
`timescale 1ns/10ps
`include "cts_status_defs.svh"

module cts_status #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  // host bus
  input  wire cts_status_pkg::host_cyc_s host_in,
  input  wire logic [DATA_W-1:0]         host_data_bus_in,
  output logic [DATA_W-1:0]              host_data_bus_out,
  output logic                           host_data_bus_oe_n_out,
  output logic [15:0]                    reg_sel_out,
  // modem side
  input  wire logic                      cts_n_in,
  // configuration
  input  wire logic                      msi_enable_in,
  input  wire logic                      auto_cts_in,
  input  wire logic                      dma_enable_in,
  input  wire logic [1:0]                dma_chan_sel_in,
  input  wire logic                      dma_need_in,
  input  wire logic                      tx_ready_in,
  // dma acknowledges
  input  wire logic                      dma_ack_chan_zero_n_in,
  input  wire logic                      dma_ack_chan_one_n_in,
  input  wire logic                      dma_ack_chan_three_n_in,
  // status
  output cts_status_pkg::dma_req_s       dma_req_out,
  output logic                           dma_ack_seen_out,
  output logic                           tx_go_out,
  output logic                           msi_irq_out,
  output logic [DATA_W-1:0]              modem_status_register_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic                       cts_meta_reg, cts_meta_next;
  logic                       cts_sync_reg, cts_sync_next;
  logic                       cts_prev_reg, cts_prev_next;
  logic                       dcts_reg, dcts_next;
  logic                       rd_prev_reg, rd_prev_next;
  cts_status_pkg::rd_state_e  rd_state_reg, rd_state_next;
  logic [DATA_W-1:0]          dout_reg, dout_next;
  logic                       oe_n_reg, oe_n_next;
  logic [15:0]                sel_reg, sel_next;
  cts_status_pkg::dma_req_s   req_reg, req_next;
  logic                       ack_reg, ack_next;
  logic                       go_reg, go_next;
  logic                       irq_reg, irq_next;
  logic [DATA_W-1:0]          msr_reg, msr_next;

  logic                       access;
  logic                       rd_start;
  logic                       msr_read;
  logic                       cts_change;
  logic [2:0]                 ack_n;

  // ****************************************************************
  // next state of the clear-to-send status
  // ****************************************************************
  always_comb
  begin
    cts_meta_next = cts_n_in;
    // only the second stage feeds the change detector
    cts_sync_next = cts_meta_reg;                                   // see R10
    cts_prev_next = cts_sync_reg;
    cts_change    = cts_sync_reg ^ cts_prev_reg;                    // see R10

    // a change in the clearing cycle still leaves the flag set
    dcts_next = cts_change | (dcts_reg & ~msr_read);                // see R2

    msr_next = '0;
    msr_next[`MSR_CTS_BIT]  = ~cts_sync_reg;                        // see R1
    msr_next[`MSR_DCTS_BIT] = dcts_next;                            // see R2

    // auto-cts owns the pin, so its toggling must not disturb the host
    irq_next = msi_enable_in & ~auto_cts_in & dcts_next;            // see R3
    go_next  = tx_ready_in & (~auto_cts_in | ~cts_sync_reg);        // see R4
  end

  // ****************************************************************
  // clear-to-send status registers
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      // the synchroniser starts at the idle level, so reset makes no false change
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
      cts_prev_reg <= 1'b1;
      dcts_reg     <= 1'b0;
      go_reg       <= 1'b0;
      irq_reg      <= 1'b0;
      msr_reg      <= '0;
    end
    else
    begin
      cts_meta_reg <= cts_meta_next;
      cts_sync_reg <= cts_sync_next;
      cts_prev_reg <= cts_prev_next;
      dcts_reg     <= dcts_next;
      go_reg       <= go_next;
      irq_reg      <= irq_next;
      msr_reg      <= msr_next;
    end
  end

  // ****************************************************************
  // next state of the host read port
  // ****************************************************************
  always_comb
  begin
    access       = ~host_in.cs_n;                                   // see R6
    rd_start     = access & ~host_in.rd_n & rd_prev_reg;
    rd_prev_next = ~(access & ~host_in.rd_n);

    // one-hot select, nothing selected without chip select
    sel_next = 16'h0000;
    if (access)
    begin
      sel_next[host_in.addr] = 1'b1;                                // see R5
    end
    // only the first cycle of a read clears the change flag
    msr_read = rd_start & (host_in.addr == `MSR_ADDR);              // see R2

    rd_state_next = rd_state_reg;
    dout_next     = dout_reg;
    oe_n_next     = 1'b1;
    unique case (rd_state_reg)
      cts_status_pkg::ST_IDLE:
      begin
        if (rd_start)
        begin
          rd_state_next = cts_status_pkg::ST_READ;
          dout_next     = (host_in.addr == `MSR_ADDR) ? msr_reg : '0;  // see R7
          oe_n_next     = 1'b0;
        end
      end
      cts_status_pkg::ST_READ:
      begin
        oe_n_next = ~(access & ~host_in.rd_n);
        // a one-cycle strobe returns to idle at once, ready for the next read
        if (oe_n_next)
        begin
          rd_state_next = cts_status_pkg::ST_IDLE;
        end
        else
        begin
          rd_state_next = cts_status_pkg::ST_HOLD;
        end
      end
      cts_status_pkg::ST_HOLD:
      begin
        oe_n_next = ~(access & ~host_in.rd_n);
        if (oe_n_next)
        begin
          rd_state_next = cts_status_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // host read port registers
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_prev_reg  <= 1'b1;
      rd_state_reg <= cts_status_pkg::ST_IDLE;
      dout_reg     <= '0;
      oe_n_reg     <= 1'b1;
      sel_reg      <= 16'h0000;
    end
    else
    begin
      rd_prev_reg  <= rd_prev_next;
      rd_state_reg <= rd_state_next;
      dout_reg     <= dout_next;
      oe_n_reg     <= oe_n_next;
      sel_reg      <= sel_next;
    end
  end

  // ****************************************************************
  // next state of the dma handshake
  // ****************************************************************
  always_comb
  begin
    req_next.req = 3'b000;
    if (dma_enable_in & dma_need_in)
    begin
      unique case (dma_chan_sel_in)
        `CHAN_ZERO:  req_next.req = 3'b001;                         // see R9
        `CHAN_ONE:   req_next.req = 3'b010;
        `CHAN_THREE: req_next.req = 3'b100;
        default:     req_next.req = 3'b000;
      endcase
    end
    // an acknowledge counts only on the channel that is requesting
    ack_n    = {dma_ack_chan_three_n_in, dma_ack_chan_one_n_in, dma_ack_chan_zero_n_in};
    ack_next = |(req_reg.req & ~ack_n);                             // see R8
  end

  // ****************************************************************
  // dma handshake registers
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      req_reg <= '0;
      ack_reg <= 1'b0;
    end
    else
    begin
      req_reg <= req_next;
      ack_reg <= ack_next;
    end
  end

  assign host_data_bus_out         = dout_reg;
  assign host_data_bus_oe_n_out    = oe_n_reg;
  assign reg_sel_out               = sel_reg;
  assign dma_req_out               = req_reg;
  assign dma_ack_seen_out          = ack_reg;
  assign tx_go_out                 = go_reg;
  assign msi_irq_out               = irq_reg;
  assign modem_status_register_out = msr_reg;

endmodule

// ==== core/cts_status_defs.svh ====
// constants for the clear-to-send status and host pin block
`ifndef CTS_STATUS_DEFS_SVH
`define CTS_STATUS_DEFS_SVH

`define MSR_ADDR        4'h6
`define MSR_CTS_BIT     4
`define MSR_DCTS_BIT    0
`define DATA_W          8
`define ADDR_W          4
`define CHAN_ZERO       2'h0
`define CHAN_ONE        2'h1
`define CHAN_THREE      2'h2

`endif

// ==== core/cts_status_pkg.sv ====
// types for the clear-to-send status and host pin block
package cts_status_pkg;

  // one host bus cycle as seen by the device
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_cyc_s;

  // dma handshake request lines, one bit per channel
  typedef struct packed {
    logic [2:0] req;
  } dma_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_HOLD = 3'b100
  } rd_state_e;

endpackage

// ==== tb/cts_status_properties.sv ====
// assertions for the cts status block
`timescale 1ns/10ps
`include "cts_status_defs.svh"
module cts_status_properties (
  // watched ports
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  input wire cts_status_pkg::host_cyc_s host_in,
  input wire logic [7:0]                host_data_bus_out,
  input wire logic                      host_data_bus_oe_n_out,
  input wire logic [15:0]               reg_sel_out,
  input wire logic                      cts_n_in,
  input wire logic                      msi_enable_in,
  input wire logic                      auto_cts_in,
  input wire logic                      tx_go_out,
  input wire logic                      msi_irq_out,
  input wire logic [7:0]                modem_status_register_out
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // age gate keeps $past from reaching back into reset
  logic [2:0] age_reg;
  logic [2:0] age_next;
  wire        up = age_reg[2];
  wire        rd = !host_in.cs_n && !host_in.rd_n;
  wire  [7:0] m  = modem_status_register_out;
  always_comb age_next = age_reg + {2'h0, !up};
  always_ff @(posedge clk_in) age_reg <= rst_in ? 3'h0 : age_next;
  sequence rd_s;
    rd && !$past(rd);
  endsequence
  chk_cts_level: assert property (up |-> m[4] == !$past(cts_n_in, 3))
    else $error("cts level wrong");
  chk_delta_set: assert property (up && $changed(m[4]) |=> m[0])
    else $error("delta not set");
  chk_delta_hold: assert property (m[0] && !rd && !$past(rd) |=> m[0])
    else $error("delta lost");
  chk_irq_gate: assert property (msi_irq_out |-> m[0] && $past(msi_enable_in && !auto_cts_in))
    else $error("irq not gated");
  chk_tx_gate: assert property (tx_go_out |-> !$past(auto_cts_in) || m[4] || $past(m[4]))
    else $error("tx not gated");
  chk_sel_decode: assert property (up |-> reg_sel_out ==
    ($past(host_in.cs_n) ? 16'h0 : 16'h1 << $past(host_in.addr)))
    else $error("select wrong");
  chk_read_drive: assert property (rd_s |=> !host_data_bus_oe_n_out)
    else $error("read not answered");
  chk_cs_ignore: assert property (host_in.cs_n |=> host_data_bus_oe_n_out)
    else $error("bus driven unselected");
  chk_read_data: assert property (rd_s ##0 (host_in.addr == `MSR_ADDR) |=>
    host_data_bus_out == $past(m))
    else $error("read data wrong");
endmodule
bind cts_status cts_status_properties i_chk (.clk_in, .rst_in, .host_in, .host_data_bus_out,
  .host_data_bus_oe_n_out, .reg_sel_out, .cts_n_in, .msi_enable_in, .auto_cts_in, .tx_go_out,
  .msi_irq_out, .modem_status_register_out);

// ==== tb/dma_ctrl_model.sv ====
// dma controller model answering requests
`timescale 1ns/10ps
module dma_ctrl_model (
  // handshake
  input  wire logic                     clk_in,
  input  wire logic                     slow_in,
  input  wire cts_status_pkg::dma_req_s req_in,
  output logic                          ack_n_out [3]
);
  // ****
  // acknowledge logic
  // ****
  // slow mode waits a cycle, as a busy bus arbiter would
  logic [2:0] seen_reg = 3'h0;
  logic [2:0] ack_reg  = 3'h0;
  always @(posedge clk_in)
  begin
    seen_reg <= req_in.req;
    ack_reg  <= slow_in ? seen_reg & req_in.req : req_in.req;
  end
  assign ack_n_out = '{!ack_reg[0], !ack_reg[1], !ack_reg[2]};
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the cts status block
`timescale 1ns/10ps
`include "cts_status_defs.svh"
module testbench;
  // ****
  // stimulus and checking
  // ****
  logic clk_in = 1'b0, rst_in = 1'b1, cts_n = 1'b1, pc = 1'b1, oe_q = 1'b1, d;
  logic msi = 1'b0, auto = 1'b0, den = 1'b0, need = 1'b0, txr = 1'b0, slow = 1'b0;
  logic [1:0] sel = 2'h3;
  logic [7:0] dout, modem_status_register, q[$];
  logic [15:0] rsel;
  logic oe_n, ag, txg, irq, ak [3];
  cts_status_pkg::host_cyc_s hc = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
  cts_status_pkg::dma_req_s rq;
  int err_count = 0, num_checks = 0;
  cts_status i_dut (.clk_in, .rst_in, .host_in(hc), .host_data_bus_in(8'h00),
    .host_data_bus_out(dout), .host_data_bus_oe_n_out(oe_n), .reg_sel_out(rsel),
    .cts_n_in(cts_n), .msi_enable_in(msi), .auto_cts_in(auto), .dma_enable_in(den),
    .dma_chan_sel_in(sel), .dma_need_in(need), .tx_ready_in(txr),
    .dma_ack_chan_zero_n_in(ak[0]), .dma_ack_chan_one_n_in(ak[1]),
    .dma_ack_chan_three_n_in(ak[2]), .dma_req_out(rq), .dma_ack_seen_out(ag),
    .tx_go_out(txg), .msi_irq_out(irq), .modem_status_register_out(modem_status_register));
  dma_ctrl_model i_dma (.clk_in, .slow_in(slow), .req_in(rq), .ack_n_out(ak));
  initial forever #25 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %0t level got %b want %b", $time, got, exp);
    end
  endtask
  // read held three cycles, rd_n high one cycle after
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    hc = '{1'b0, 1'b0, 1'b1, a, 8'($urandom)};
    q.push_back(e);
    repeat (3) @(negedge clk_in);
    hc = '{1'b1, 1'b1, 1'b1, a, 8'h00};
    @(negedge clk_in);
  endtask
  always @(negedge clk_in)
  begin
    if (!oe_n && oe_q)
    begin
      chk_bit(q.size() > 0, 1'b1);
      if (q.size() > 0)
        chk(dout, q.pop_front());
    end
    oe_q = oe_n;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hb091));
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      {cts_n, msi, auto, txr, slow} = 5'($urandom);
      repeat (6) @(negedge clk_in);
      d = cts_n ^ pc;
      chk(modem_status_register, {3'h0, !cts_n, 3'h0, d});
      chk_bit(irq, d & msi & !auto);
      chk_bit(txg, txr & (!auto | !cts_n));
      rd(`MSR_ADDR, {3'h0, !cts_n, 3'h0, d});
      rd(`MSR_ADDR, {3'h0, !cts_n, 4'h0});
      rd(4'(i), (i % 16 == 6) ? {3'h0, !cts_n, 4'h0} : 8'h00);
      pc = cts_n;
      sel = 2'(i);
      {den, need} = 2'($urandom);
      repeat (4) @(negedge clk_in);
      chk({5'h0, rq.req}, {5'h0, 3'(3'h1 << sel) & {3{den & need}}});
      chk_bit(ag, den & need & (sel != 2'h3));
    end
    // a change that lands on the clearing read must survive it
    cts_n = !cts_n;
    repeat (2) @(negedge clk_in);
    rd(`MSR_ADDR, {3'h0, !pc, 4'h0});
    rd(`MSR_ADDR, {3'h0, !cts_n, 4'h1});
    repeat (2) @(negedge clk_in);
    chk_bit(q.size() == 0, 1'b1);
    close_out;
  end
  initial
  begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    close_out;
  end
endmodule
